// ---- design/osf_oscillator_status_flags.v ----
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`include "osf_consts.vh"

module osf_oscillator_status_flags (
	input wire clk, // 100 MHz system clock
	input wire sys_rst, // async reset, active high
	input wire hfWithin2pct, // hf oscillator within 2 percent
	input wire hfWithinHalfPct, // hf oscillator within 0.5 percent
	input wire mfOscReady, // medium-frequency oscillator ready
	input wire lfOscReady, // low-frequency oscillator ready
	input wire [3:0] s_axi_awaddr, // write address
	input wire s_axi_awvalid, // write address valid
	output reg s_axi_awready, // write address ready
	input wire [31:0] s_axi_wdata, // write data, discarded
	input wire [3:0] s_axi_wstrb, // write strobes, discarded
	input wire s_axi_wvalid, // write data valid
	output reg s_axi_wready, // write data ready
	output reg [1:0] s_axi_bresp, // write response
	output reg s_axi_bvalid, // write response valid
	input wire s_axi_bready, // write response ready
	input wire [3:0] s_axi_araddr, // read address
	input wire s_axi_arvalid, // read address valid
	output reg s_axi_arready, // read address ready
	output reg [31:0] s_axi_rdata, // read data
	output reg [1:0] s_axi_rresp, // read response
	output reg s_axi_rvalid, // read data valid
	input wire s_axi_rready, // read data ready
	output reg [7:0] statusFlags // registered copy of the status register, one cycle behind the inputs
);

	reg awHeld; // write address taken, response not yet issued
	reg wHeld; // write data taken, response not yet issued
	reg [3:0] awAddrHeld; // address of the write in flight
	reg [7:0] next_status; // flags as they stand this cycle
	reg [1:0] next_bresp; // response for the write in flight
	reg [31:0] next_rdata; // word for the read being taken
	reg [1:0] next_rresp; // response for the read being taken
	wire awTake; // write address accepted this cycle
	wire wTake; // write data accepted this cycle
	wire respDue; // both halves held, response goes out
	wire arTake; // read address accepted this cycle

	// assemble flags from oscillator condition
	always @*
	begin
		next_status = `OSF_STATUS_RST;
		next_status[`OSF_BIT_LOCK] = hfWithin2pct;
		next_status[`OSF_BIT_STABLE] = hfWithinHalfPct;
		next_status[`OSF_BIT_MF_READY] = mfOscReady;
		next_status[`OSF_BIT_LF_READY] = lfOscReady;
	end

	// sample once per cycle; no software path reaches it
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			statusFlags <= `OSF_STATUS_RST;
		else
			statusFlags <= next_status;
	end

	// acceptance terms; no write is taken while bvalid stands, no read while rvalid stands
	assign awTake = s_axi_awvalid && !awHeld && !s_axi_awready && !s_axi_bvalid;
	assign wTake = s_axi_wvalid && !wHeld && !s_axi_wready && !s_axi_bvalid;
	assign respDue = awHeld && wHeld && !s_axi_bvalid;
	assign arTake = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

	// write address ready: one-cycle pulse per accepted address
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			s_axi_awready <= 1'h0;
		else
			s_axi_awready <= awTake;
	end

	// write data ready: one-cycle pulse, data itself is dropped
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			s_axi_wready <= 1'h0;
		else
			s_axi_wready <= wTake;
	end

	// address half held until the response goes out, so either order works
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			awHeld <= 1'h0;
		else if (awTake)
			awHeld <= 1'h1;
		else if (respDue)
			awHeld <= 1'h0;
	end

	// data half held the same way
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			wHeld <= 1'h0;
		else if (wTake)
			wHeld <= 1'h1;
		else if (respDue)
			wHeld <= 1'h0;
	end

	// address kept only to choose the response code
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			awAddrHeld <= 4'h0;
		else if (awTake)
			awAddrHeld <= s_axi_awaddr;
	end

	// writes never alter flags: status is read-only, id is constant
	always @*
	begin
		next_bresp = `OSF_RESP_SLVERR;
		if (awAddrHeld[3:2] == `OSF_IDX_STATUS || awAddrHeld[3:2] == `OSF_IDX_ID)
			next_bresp = `OSF_RESP_OKAY;
	end

	// write response valid stands until the master takes it
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			s_axi_bvalid <= 1'h0;
		else if (respDue)
			s_axi_bvalid <= 1'h1;
		else if (s_axi_bvalid && s_axi_bready)
			s_axi_bvalid <= 1'h0;
	end

	// response code loaded with the valid and kept afterwards
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			s_axi_bresp <= `OSF_RESP_OKAY;
		else if (respDue)
			s_axi_bresp <= next_bresp;
	end

	// read address ready: one-cycle pulse, one read in flight at most
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			s_axi_arready <= 1'h0;
		else
			s_axi_arready <= arTake;
	end

	// read valid rises with arready and stands until rready
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			s_axi_rvalid <= 1'h0;
		else if (arTake)
			s_axi_rvalid <= 1'h1;
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'h0;
	end

	// read decode; status comes from the live inputs, not the lagging port copy
	always @*
	begin
		next_rdata = 32'h00000000;
		next_rresp = `OSF_RESP_OKAY;
		case (s_axi_araddr[3:2])
			`OSF_IDX_STATUS:
				next_rdata = {24'h000000, next_status};
			`OSF_IDX_ID:
				next_rdata = `OSF_ID_VALUE; // arbitrary id value
			default:
				next_rresp = `OSF_RESP_SLVERR;
		endcase
	end

	// read word captured at acceptance, held while rvalid stands
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			s_axi_rdata <= 32'h00000000;
		else if (arTake)
			s_axi_rdata <= next_rdata;
	end

	// read response captured alongside the data
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			s_axi_rresp <= `OSF_RESP_OKAY;
		else if (arTake)
			s_axi_rresp <= next_rresp;
	end

endmodule // osf_oscillator_status_flags

// ---- include/osf_consts.vh ----
`ifndef OSF_CONSTS_VH
`define OSF_CONSTS_VH

// register map, byte addresses
`define OSF_ADDR_STATUS 4'h0
`define OSF_ADDR_ID 4'h4
// word index of each register, address bits 3:2
`define OSF_IDX_STATUS 2'h0
`define OSF_IDX_ID 2'h1
// status field positions
`define OSF_BIT_STABLE 0
`define OSF_BIT_LF_READY 1
`define OSF_BIT_MF_READY 2
`define OSF_BIT_LOCK 3
// status reset value and id constant
`define OSF_STATUS_RST 8'h00
`define OSF_ID_VALUE 32'h0000A5C3
// axi responses
`define OSF_RESP_OKAY 2'h0
`define OSF_RESP_SLVERR 2'h2

`endif

// ---- tb/osf_status_sva.sv ----
`timescale 1ns/1ns
module osf_status_sva (
	input wire clk, // clk
	input wire sys_rst, // rst
	input wire hfWithin2pct, // 2%
	input wire hfWithinHalfPct, // 0.5%
	input wire mfOscReady, // mf
	input wire lfOscReady, // lf
	input wire [7:0] statusFlags // out
);
reg [3:0] prev;
reg live;
default clocking @(posedge clk); endclocking
default disable iff (sys_rst);
// inputs one clock back; live masks the first edge, flags still hold reset zeros there
always @(posedge clk or posedge sys_rst)
begin
	live <= !sys_rst;
	prev <= {hfWithin2pct, mfOscReady, lfOscReady, hfWithinHalfPct};
end
a_lock_flag: assert property (live |-> statusFlags[3]==prev[3]) else $error("lock");
a_stable_flag: assert property (live |-> statusFlags[0]==prev[0]) else $error("stab");
a_mf_ready: assert property (live |-> statusFlags[2]==prev[2]) else $error("mf");
a_lf_ready: assert property (live |-> statusFlags[1]==prev[1]) else $error("lf");
a_upper_zero: assert property (statusFlags[7:4]==4'h0) else $error("upper");
endmodule // osf_status_sva
bind osf_oscillator_status_flags osf_status_sva chk (.clk(clk), .sys_rst(sys_rst),
	.hfWithin2pct(hfWithin2pct), .hfWithinHalfPct(hfWithinHalfPct),
	.mfOscReady(mfOscReady), .lfOscReady(lfOscReady), .statusFlags(statusFlags));

// ---- tb/osf_oscillator_status_flags_tb.sv ----
`timescale 1ns/1ns
`include "osf_consts.vh"
module osf_oscillator_status_flags_tb;
reg clk=0, sys_rst=1, aw=0, w=0, br=0, ar=0, rr=0;
reg [3:0] osc=0, awa=0, ara=0;
reg [31:0] wd=0, rdv, seed=28;
wire awr, wr, bv, arr, rv;
wire [1:0] bre, rre;
wire [31:0] rdt;
wire [7:0] sf;
integer err_count=0, n_checks=0, cyc=0, i;
osf_oscillator_status_flags uut (.clk(clk), .sys_rst(sys_rst), .hfWithin2pct(osc[3]),
	.hfWithinHalfPct(osc[0]), .mfOscReady(osc[2]), .lfOscReady(osc[1]), .s_axi_awaddr(awa),
	.s_axi_awvalid(aw), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
	.s_axi_wvalid(w), .s_axi_wready(wr), .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br),
	.s_axi_araddr(ara), .s_axi_arvalid(ar), .s_axi_arready(arr), .s_axi_rdata(rdt),
	.s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr), .statusFlags(sf));
always #5 clk = ~clk;
function [31:0] xs(input [31:0] x);
	reg [31:0] y;
	begin
		y = x^(x<<13);
		y = y^(y>>17);
		xs = y^(y<<5);
	end
endfunction
// expected register word from the condition bits {2pct, mf, lf, halfpct}
function [31:0] expFlags(input [3:0] c);
begin
	expFlags = 32'h0;
	expFlags[`OSF_BIT_LOCK] = c[3];
	expFlags[`OSF_BIT_STABLE] = c[0];
	expFlags[`OSF_BIT_MF_READY] = c[2];
	expFlags[`OSF_BIT_LF_READY] = c[1];
end
endfunction
task chk(input [31:0] s, e);
begin
	n_checks = n_checks+1;
	if (s !== e)
	begin
		err_count = err_count+1;
		$display("CHECK FAILED %0t value mismatch", $time);
	end
end
endtask
task print_verdict;
begin
	$display("checks %0d errors %0d", n_checks, err_count);
	if (err_count==0 && n_checks>0) $display("Simulation passed");
	else $display("Simulation failed");
	$finish;
end
endtask
// hang guard, a full run needs under two hundred cycles
always @(posedge clk)
begin
	cyc = cyc+1;
	if (cyc==3000) begin err_count = err_count+1; print_verdict; end
end
// read: hold ar until arready, rready until rvalid
task axiRd(input [3:0] a, input [31:0] e);
begin
	ara<=a; ar<=1; rr<=1;
	do @(posedge clk); while (!arr);
	ar<=0;
	while (!rv) @(posedge clk);
	rr<=0; rdv=rdt;
	chk(rdv, e);
end
endtask
// write: aw and w offered together, each dropped once taken
task axiWr(input [3:0] a, input [1:0] e);
begin
	awa<=a; wd<=seed; aw<=1; w<=1; br<=1;
	do begin @(posedge clk); if (awr) aw<=0; if (wr) w<=0; end while (!bv);
	br<=0;
	chk(bre, e);
end
endtask
initial
begin
	repeat (5) @(posedge clk);
	sys_rst<=0;
	for (i=0; i<20; i=i+1)
	begin
		seed = xs(seed);
		osc <= (i==1) ? 4'hF : (i==0 ? 4'h0 : seed[3:0]);
		repeat (2) @(posedge clk);
		chk(sf, expFlags(osc));
		axiWr(`OSF_ADDR_STATUS, `OSF_RESP_OKAY);
		axiRd(`OSF_ADDR_STATUS, expFlags(osc));
		$display("test %0d done", i);
	end
	axiRd(4'h8, 32'h0);
	chk(rre, `OSF_RESP_SLVERR);
	axiRd(`OSF_ADDR_ID, `OSF_ID_VALUE);
	chk(rre, `OSF_RESP_OKAY);
	axiWr(4'hC, `OSF_RESP_SLVERR);
	axiWr(`OSF_ADDR_ID, `OSF_RESP_OKAY);
	chk(sf, expFlags(osc));
	print_verdict;
end
endmodule // osf_oscillator_status_flags_tb
